/* File: core/usrx_regs.vh */
`ifndef USRX_REGS_VH
`define USRX_REGS_VH

// ----------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------
`define USRX_A_TXCTL 8'h00
`define USRX_A_BAUD 8'h04
`define USRX_A_TBUF 8'h08
`define USRX_A_RBUF 8'h0c
`define USRX_A_INT 8'h10
`define USRX_A_DIR 8'h14
`define USRX_A_RC 8'h18

// ----------------------------------------------------------
// field positions
// ----------------------------------------------------------
`define USRX_RC_SERIAL_PORT_ENABLE 7
`define USRX_RC_RX9 6
`define USRX_RC_SINGLE_RECEIVE_ENABLE 5
`define USRX_RC_CONTINUOUS_RECEIVE_ENABLE 4
`define USRX_RC_FRAMING_ERROR_FLAG 2
`define USRX_RC_OVERRUN_ERROR_FLAG 1
`define USRX_RC_RECEIVED_NINTH_BIT 0
`define USRX_TX_CLOCK_SOURCE_SELECT 7
`define USRX_TX_TX9 6
`define USRX_TX_TRANSMIT_ENABLE 5
`define USRX_TX_SYNC 4
`define USRX_TX_TRMT 1
`define USRX_TX_TRANSMIT_NINTH_BIT 0
`define USRX_IN_RECEIVE_BUFFER_FULL_FLAG 0
`define USRX_IN_TRANSMIT_BUFFER_EMPTY_FLAG 1
`define USRX_IN_RECEIVE_INTERRUPT_ENABLE 2
`define USRX_IN_TRANSMIT_INTERRUPT_ENABLE 3
`define USRX_IN_GIE 4

// ----------------------------------------------------------
// reset values, timing and async receiver state codes
// ----------------------------------------------------------
`define USRX_RC_RST 8'h00
`define USRX_DIR_RST 2'h3
`define USRX_EIGHT_BITS 4'h8
`define USRX_NINE_BITS 4'h9
`define USRX_ASYNC_SHIFT 6
`define USRX_AR_IDLE 4'h1
`define USRX_AR_START 4'h2
`define USRX_AR_DATA 4'h4
`define USRX_AR_STOP 4'h8

`endif

/* File: core/usrx_sync.v */
`timescale 1ns/1ps
`default_nettype none
module usrx_sync #(
  parameter W = 2
) (
  input wire clk, // system clock
  input wire rst, // async reset, high
  input wire [W-1:0] d, // raw inputs from pins
  output reg [W-1:0] q // two-flop synchronised copy
);
  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: core/usrx_top.v */
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "usrx_regs.vh"
module usrx_top #(
  parameter ASYNC_SHIFT = `USRX_ASYNC_SHIFT
) (
  input wire clk, // 100 MHz system clock
  input wire rst, // async reset, high
  input wire hsel, // ahb slave select
  input wire [31:0] haddr, // ahb address
  input wire [1:0] htrans, // ahb transfer type
  input wire hwrite, // ahb write
  input wire [2:0] hsize, // ahb size, word only
  input wire [31:0] hwdata, // ahb write data
  input wire hready, // ahb bus ready
  output wire hreadyout, // never stalls
  output wire hresp, // always okay
  output reg [31:0] hrdata, // ahb read data
  input wire core_sleep, // core halted, oscillator off
  input wire ck_in, // shift clock pin level
  output reg ck_out, // shift clock drive
  output wire ck_oe, // shift clock enable
  input wire dt_in, // data pin level
  output reg dt_out, // data drive
  output wire dt_oe, // data enable
  output reg wake_request, // wakes sleeping core
  output reg int_request // branch to vector
);

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  reg rc_serial_port_enable, rc_rx9, rc_single_receive_enable, rc_continuous_receive_enable, rc_framing_error_flag, rc_overrun_error_flag, rc_received_ninth_bit;
  reg tx_clock_source_select, tx_tx9, tx_transmit_enable, tx_sync, tx_transmit_ninth_bit;
  reg receive_interrupt_enable, transmit_interrupt_enable, gie;
  reg [7:0] baud_div;
  reg [1:0] dir;
  reg [7:0] tbuf;
  reg tbuf_full;
  reg [8:0] transmit_shift_reg;
  reg tsr_busy;
  reg [3:0] tx_cnt;
  reg [8:0] receive_shift_reg;
  reg [3:0] rx_cnt;
  reg [7:0] rbuf;
  reg receive_buffer_full_flag;
  reg rx_fin, fin_framing_error_flag;
  reg [3:0] ar_state;
  reg [14:0] ar_cnt;
  reg [8:0] mclk_cnt;
  reg mclk, m_rise, m_fall;
  reg s_ck_d, s_dt_d;
  reg wr_pend, rd_pop;
  reg [7:0] wr_addr;
  reg [7:0] rd_val;
  wire [1:0] pins_s;
  wire s_ck = pins_s[1];
  wire s_dt = pins_s[0];

  function [3:0] usrx_nbits;
    input nine;
    begin
      usrx_nbits = nine ? `USRX_NINE_BITS : `USRX_EIGHT_BITS;
    end
  endfunction

  // ----------------------------------------------------------
  // pin synchronisers and mode decode
  // ----------------------------------------------------------
  usrx_sync #(.W(2)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({ck_in, dt_in}),
    .q(pins_s)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ck_d <= 1'b0;
      s_dt_d <= 1'b1;
    end else begin
      s_ck_d <= s_ck;
      s_dt_d <= s_dt;
    end
  end

  wire port_on = rc_serial_port_enable & (dir == `USRX_DIR_RST);
  wire master = tx_sync & tx_clock_source_select;
  wire slave = tx_sync & ~tx_clock_source_select;
  wire transmit_buffer_empty_flag = ~tbuf_full;
  // master also honours single receive, slave only continuous
  wire rx_req = rc_continuous_receive_enable | (master & rc_single_receive_enable);
  wire rx_on = tx_sync & port_on & rx_req & ~rc_overrun_error_flag;
  wire tx_go = tx_sync & port_on & tx_transmit_enable & ~rx_on;
  wire s_rise = s_ck & ~s_ck_d;
  wire s_fall = ~s_ck & s_ck_d;
  // both modes share one shifter; only the edge source differs
  wire edge_r = master ? m_rise : (slave & s_rise);
  wire edge_f = master ? m_fall : (slave & s_fall);
  wire [3:0] rx_n = usrx_nbits(rc_rx9);
  wire [3:0] tx_n = usrx_nbits(tx_tx9);
  wire [14:0] bit_per = {7'h00, baud_div} + 15'h0001;
  wire [14:0] ar_full = (bit_per << ASYNC_SHIFT) - 15'h0001;
  wire ar_on = ~tx_sync & port_on & rc_continuous_receive_enable & ~rc_overrun_error_flag;

  // ----------------------------------------------------------
  // master shift clock: half period is 2*(divisor+1) cycles
  // ----------------------------------------------------------
  // the oscillator stops in sleep, so a master halts its clock
  wire m_run = master & port_on & ~core_sleep & (tsr_busy | rx_on);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mclk_cnt <= 9'h000;
      mclk <= 1'b0;
      m_rise <= 1'b0;
      m_fall <= 1'b0;
    end else begin
      m_rise <= 1'b0;
      m_fall <= 1'b0;
      if (!m_run) begin
        mclk_cnt <= 9'h000;
        mclk <= 1'b0;
      end else if (mclk_cnt == 9'h000) begin
        mclk_cnt <= {baud_div, 1'b1};
        mclk <= ~mclk;
        m_rise <= ~mclk;
        m_fall <= mclk;
      end else begin
        mclk_cnt <= mclk_cnt - 9'h001;
      end
    end
  end

  // slave leaves the clock pin to the external master
  assign ck_oe = port_on & master;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ck_out <= 1'b0;
    end else begin
      ck_out <= mclk;
    end
  end

  // ----------------------------------------------------------
  // transmit: holding buffer and shift register
  // ----------------------------------------------------------
  wire tb_write = wr_pend & (wr_addr == `USRX_A_TBUF);
  wire tsr_load = tbuf_full & ~tsr_busy & tx_go;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tbuf <= 8'h00;
      tbuf_full <= 1'b0;
      transmit_shift_reg <= 9'h000;
      tsr_busy <= 1'b0;
      tx_cnt <= 4'h0;
      dt_out <= 1'b1;
    end else begin
      // a word loaded while one moves on stays queued
      if (tb_write) begin
        tbuf <= hwdata[7:0];
        tbuf_full <= 1'b1;
      end else if (tsr_load) begin
        tbuf_full <= 1'b0;
      end
      if (!tx_go) begin
        tsr_busy <= 1'b0;
        tx_cnt <= 4'h0;
      end else if (tsr_load) begin
        transmit_shift_reg <= {tx_transmit_ninth_bit, tbuf};
        tsr_busy <= 1'b1;
        tx_cnt <= 4'h0;
        dt_out <= tbuf[0];
      end else if (tsr_busy && edge_f) begin
        // in slave mode these edges keep coming during sleep
        if (tx_cnt == tx_n - 4'h1) begin
          tsr_busy <= 1'b0;
          tx_cnt <= 4'h0;
        end else begin
          tx_cnt <= tx_cnt + 4'h1;
          dt_out <= transmit_shift_reg[tx_cnt + 4'h1];
        end
      end
    end
  end

  assign dt_oe = tx_go & tsr_busy;

  // ----------------------------------------------------------
  // receive: sync shifter and async sampler share one shift reg
  // ----------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      receive_shift_reg <= 9'h000;
      rx_cnt <= 4'h0;
      rx_fin <= 1'b0;
      fin_framing_error_flag <= 1'b0;
      ar_state <= `USRX_AR_IDLE;
      ar_cnt <= 15'h0000;
    end else begin
      rx_fin <= 1'b0;
      if (tx_sync) begin
        ar_state <= `USRX_AR_IDLE;
        if (!rx_on) begin
          rx_cnt <= 4'h0;
        end else if (edge_r) begin
          receive_shift_reg[rx_cnt] <= s_dt;
          if (rx_cnt == rx_n - 4'h1) begin
            rx_cnt <= 4'h0;
            rx_fin <= 1'b1;
            fin_framing_error_flag <= 1'b0;
          end else begin
            rx_cnt <= rx_cnt + 4'h1;
          end
        end
      end else if (!ar_on) begin
        ar_state <= `USRX_AR_IDLE;
      end else begin
        case (ar_state)
          `USRX_AR_IDLE: begin
            if (s_dt_d && !s_dt) begin
              ar_cnt <= ar_full >> 1;
              ar_state <= `USRX_AR_START;
            end
          end
          `USRX_AR_START: begin
            if (ar_cnt != 15'h0000) begin
              ar_cnt <= ar_cnt - 15'h0001;
            end else if (!s_dt) begin
              ar_cnt <= ar_full;
              rx_cnt <= 4'h0;
              ar_state <= `USRX_AR_DATA;
            end else begin
              ar_state <= `USRX_AR_IDLE;
            end
          end
          `USRX_AR_DATA: begin
            if (ar_cnt != 15'h0000) begin
              ar_cnt <= ar_cnt - 15'h0001;
            end else begin
              receive_shift_reg[rx_cnt] <= s_dt;
              ar_cnt <= ar_full;
              rx_cnt <= rx_cnt + 4'h1;
              if (rx_cnt == rx_n - 4'h1) begin
                ar_state <= `USRX_AR_STOP;
              end
            end
          end
          `USRX_AR_STOP: begin
            if (ar_cnt != 15'h0000) begin
              ar_cnt <= ar_cnt - 15'h0001;
            end else begin
              rx_fin <= 1'b1;
              fin_framing_error_flag <= ~s_dt;
              rx_cnt <= 4'h0;
              ar_state <= `USRX_AR_IDLE;
            end
          end
          default: begin
            ar_state <= `USRX_AR_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // ahb-lite slave: zero wait states, okay only
  // ----------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire a_phase = hsel & htrans[1] & hready;

  // unimplemented and unmapped bits read as zero
  always @* begin
    rd_val = 8'h00;
    case (haddr[7:0])
      `USRX_A_RC: begin
        rd_val[`USRX_RC_SERIAL_PORT_ENABLE] = rc_serial_port_enable;
        rd_val[`USRX_RC_RX9] = rc_rx9;
        rd_val[`USRX_RC_SINGLE_RECEIVE_ENABLE] = rc_single_receive_enable;
        rd_val[`USRX_RC_CONTINUOUS_RECEIVE_ENABLE] = rc_continuous_receive_enable;
        rd_val[`USRX_RC_FRAMING_ERROR_FLAG] = rc_framing_error_flag;
        rd_val[`USRX_RC_OVERRUN_ERROR_FLAG] = rc_overrun_error_flag;
        rd_val[`USRX_RC_RECEIVED_NINTH_BIT] = rc_received_ninth_bit;
      end
      `USRX_A_TXCTL: begin
        rd_val[`USRX_TX_CLOCK_SOURCE_SELECT] = tx_clock_source_select;
        rd_val[`USRX_TX_TX9] = tx_tx9;
        rd_val[`USRX_TX_TRANSMIT_ENABLE] = tx_transmit_enable;
        rd_val[`USRX_TX_SYNC] = tx_sync;
        rd_val[`USRX_TX_TRMT] = ~tsr_busy;
        rd_val[`USRX_TX_TRANSMIT_NINTH_BIT] = tx_transmit_ninth_bit;
      end
      `USRX_A_BAUD: rd_val = baud_div;
      `USRX_A_RBUF: rd_val = rbuf;
      `USRX_A_DIR: rd_val = {6'h00, dir};
      `USRX_A_INT: begin
        rd_val[`USRX_IN_RECEIVE_BUFFER_FULL_FLAG] = receive_buffer_full_flag;
        rd_val[`USRX_IN_TRANSMIT_BUFFER_EMPTY_FLAG] = transmit_buffer_empty_flag;
        rd_val[`USRX_IN_RECEIVE_INTERRUPT_ENABLE] = receive_interrupt_enable;
        rd_val[`USRX_IN_TRANSMIT_INTERRUPT_ENABLE] = transmit_interrupt_enable;
        rd_val[`USRX_IN_GIE] = gie;
      end
      default: rd_val = 8'h00;
    endcase
  end

  // read data is captured at the address edge for the data phase
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_pop <= 1'b0;
    end else begin
      wr_pend <= a_phase & hwrite;
      rd_pop <= a_phase & ~hwrite & (haddr[7:0] == `USRX_A_RBUF);
      if (a_phase) begin
        wr_addr <= haddr[7:0];
      end
      if (a_phase && !hwrite) begin
        hrdata <= {24'h000000, rd_val};
      end
    end
  end

  // ----------------------------------------------------------
  // control registers, receive buffer and flags
  // ----------------------------------------------------------
  wire rc_write = wr_pend & (wr_addr == `USRX_A_RC);
  wire rc_load = rx_fin & ~receive_buffer_full_flag;
  wire rc_over = rx_fin & receive_buffer_full_flag;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {rc_serial_port_enable, rc_rx9, rc_single_receive_enable, rc_continuous_receive_enable} <= 4'h0;
      {rc_framing_error_flag, rc_overrun_error_flag, rc_received_ninth_bit} <= 3'h0;
      {tx_clock_source_select, tx_tx9, tx_transmit_enable, tx_sync, tx_transmit_ninth_bit} <= 5'h00;
      {receive_interrupt_enable, transmit_interrupt_enable, gie} <= 3'h0;
      baud_div <= 8'h00;
      dir <= `USRX_DIR_RST;
      rbuf <= 8'h00;
      receive_buffer_full_flag <= 1'b0;
    end else begin
      if (rc_write) begin
        rc_serial_port_enable <= hwdata[`USRX_RC_SERIAL_PORT_ENABLE];
        rc_rx9 <= hwdata[`USRX_RC_RX9];
        rc_single_receive_enable <= hwdata[`USRX_RC_SINGLE_RECEIVE_ENABLE];
        rc_continuous_receive_enable <= hwdata[`USRX_RC_CONTINUOUS_RECEIVE_ENABLE];
      end else if (master && rx_fin && !rc_continuous_receive_enable) begin
        rc_single_receive_enable <= 1'b0;
      end
      // a new overrun beats a clear written in the same cycle
      if (rc_over) begin
        rc_overrun_error_flag <= 1'b1;
      end else if (rc_write && !hwdata[`USRX_RC_CONTINUOUS_RECEIVE_ENABLE]) begin
        rc_overrun_error_flag <= 1'b0;
      end
      if (rc_load) begin
        rbuf <= receive_shift_reg[7:0];
        rc_received_ninth_bit <= receive_shift_reg[8];
        rc_framing_error_flag <= fin_framing_error_flag;
        receive_buffer_full_flag <= 1'b1;
      end else if (rd_pop) begin
        receive_buffer_full_flag <= 1'b0;
      end
      if (wr_pend && wr_addr == `USRX_A_TXCTL) begin
        tx_clock_source_select <= hwdata[`USRX_TX_CLOCK_SOURCE_SELECT];
        tx_tx9 <= hwdata[`USRX_TX_TX9];
        tx_transmit_enable <= hwdata[`USRX_TX_TRANSMIT_ENABLE];
        tx_sync <= hwdata[`USRX_TX_SYNC];
        tx_transmit_ninth_bit <= hwdata[`USRX_TX_TRANSMIT_NINTH_BIT];
      end
      if (wr_pend && wr_addr == `USRX_A_BAUD) begin
        baud_div <= hwdata[7:0];
      end
      if (wr_pend && wr_addr == `USRX_A_DIR) begin
        dir <= hwdata[1:0];
      end
      if (wr_pend && wr_addr == `USRX_A_INT) begin
        receive_interrupt_enable <= hwdata[`USRX_IN_RECEIVE_INTERRUPT_ENABLE];
        transmit_interrupt_enable <= hwdata[`USRX_IN_TRANSMIT_INTERRUPT_ENABLE];
        gie <= hwdata[`USRX_IN_GIE];
      end
    end
  end

  // ----------------------------------------------------------
  // wake and interrupt request
  // ----------------------------------------------------------
  wire flag_ev = (receive_buffer_full_flag & receive_interrupt_enable) | (transmit_buffer_empty_flag & transmit_interrupt_enable);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_request <= 1'b0;
      int_request <= 1'b0;
    end else begin
      wake_request <= flag_ev;
      int_request <= flag_ev & gie;
    end
  end
endmodule
`default_nettype wire

/* File: bench/usrx_chk_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usrx_regs.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module usrx_chk (
  input wire clk, // system clock
  input wire rst, // async reset, high
  input wire hsel, // ahb select
  input wire [31:0] haddr, // ahb address
  input wire [1:0] htrans, // transfer type
  input wire hwrite, // ahb write
  input wire [31:0] hwdata, // write data
  input wire hready, // bus ready
  input wire hreadyout, // slave ready
  input wire hresp, // slave response
  input wire [31:0] hrdata, // read data
  input wire core_sleep, // core halted
  input wire ck_in, // clock pin level
  input wire ck_oe, // clock drive enable
  input wire dt_out, // data drive
  input wire dt_oe, // data drive enable
  input wire wake_request, // wake line
  input wire int_request // vector branch
);
  reg dp_wr;
  reg [7:0] dp_a;
  reg clock_source_select_q;
  reg serial_port_enable_q;
  reg [1:0] dir_q;
  reg gie_q;
  reg ck_d;
  reg [3:0] since_fall;
  wire take = hsel & htrans[1] & hready;
  wire port_on = serial_port_enable_q & (dir_q == 2'h3);
  // mirror of mode bits, committed at the end of the data phase
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dp_wr <= 1'b0;
      dp_a <= 8'h00;
      clock_source_select_q <= 1'b0;
      serial_port_enable_q <= 1'b0;
      dir_q <= 2'h3;
      gie_q <= 1'b0;
      ck_d <= 1'b0;
      since_fall <= 4'hf;
    end else begin
      dp_wr <= take & hwrite;
      dp_a <= haddr[7:0];
      if (dp_wr && dp_a == `USRX_A_TXCTL) clock_source_select_q <= hwdata[7];
      if (dp_wr && dp_a == `USRX_A_RC) serial_port_enable_q <= hwdata[7];
      if (dp_wr && dp_a == `USRX_A_DIR) dir_q <= hwdata[1:0];
      if (dp_wr && dp_a == `USRX_A_INT) gie_q <= hwdata[4];
      ck_d <= ck_in;
      // raw pin, so the bound below covers the sync delay
      if (ck_d && !ck_in) since_fall <= 4'h0;
      else if (since_fall != 4'hf) since_fall <= since_fall + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd_rc;
    take && !hwrite && haddr[7:0] == `USRX_A_RC;
  endsequence
  sequence s_rd_far;
    take && !hwrite && haddr[7:0] > `USRX_A_RC;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_rc_hole_zero: assert property (s_rd_rc |=> hrdata[31:8] == 24'h0 && !hrdata[3])
    else $error("status read shows unimplemented bits");
  a_unmapped_zero: assert property (s_rd_far |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_slave_no_clk: assert property (!clock_source_select_q && !$past(clock_source_select_q) |-> !ck_oe)
    else $error("slave drives the clock pin");
  a_port_off: assert property (!port_on && !$past(port_on) |-> !dt_oe && !ck_oe)
    else $error("disabled port drives a pin");
  a_int_wake: assert property (int_request |-> wake_request && (gie_q || $past(gie_q)))
    else $error("vector request without wake or global enable");
  a_shift_on_fall: assert property (!clock_source_select_q && dt_oe && $past(dt_oe) && $changed(dt_out) |-> since_fall <= 4'h8)
    else $error("data changed away from a clock fall");
  a_sleep_keeps: assert property (!clock_source_select_q && $rose(core_sleep) && dt_oe && since_fall == 4'hf |=> dt_oe)
    else $error("sleep stopped slave transmit");
endmodule
`default_nettype wire

/* File: bench/usrx_sync_master.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// external master owning the shift clock
// ----------------------------------------
module usrx_sync_master (
  output var logic ck, // shift clock, idle low
  output var logic dt, // data drive
  output var logic dt_en, // data drive enable
  input wire logic dt_line // resolved data pin
);
  initial begin
    ck = 1'b0;
    dt = 1'b1;
    dt_en = 1'b0;
  end
  // one frame, lsb first; the clock stands still outside frames
  task automatic frame(input logic [8:0] tx, input int n, input logic drv, output logic [8:0] rx);
    rx = 9'h000;
    dt_en = drv;
    for (int i = 0; i < n; i++) begin
      dt = tx[i];
      #40 ck = 1'b1;
      rx[i] = dt_line;
      #40 ck = 1'b0;
    end
    dt_en = 1'b0;
  endtask
  // async frame at divisor 0, 64 clocks a bit, lsb first
  // the line is left driven high so that no false start bit follows
  task automatic async_frame(input logic [7:0] d, input logic stop);
    dt = 1'b1;
    dt_en = 1'b1;
    #640 dt = 1'b0;
    for (int i = 0; i < 8; i++) begin
      #640 dt = d[i];
    end
    #640 dt = stop;
    #640 dt = 1'b1;
    #640;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usrx_regs.vh"
module tb_top;
  logic clk, rst, hsel, hwrite, core_sleep, dt_last, ck_line, dt_line;
  logic [31:0] haddr, hwdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [8:0] rxw;
  time t0;
  logic [8:0] words [2] = '{9'h13c, 9'h0c3};
  wire hreadyout, hresp, ck_out, ck_oe, dt_out, dt_oe, wake_request, int_request, m_ck, m_dt, m_en;
  wire [31:0] hrdata;
  wire hready = hreadyout;
  int errors, cmp_count, cyc;
  // pins resolved from every driver; a released line shows the inverse
  assign ck_line = ck_oe ? ck_out : m_ck;
  assign dt_line = dt_oe ? dt_out : (m_en ? m_dt : ~dt_last);
  always @(posedge clk) if (dt_oe || m_en) dt_last <= dt_line;
  usrx_top #(.ASYNC_SHIFT(`USRX_ASYNC_SHIFT)) dut_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_sleep(core_sleep), .ck_in(ck_line),
    .ck_out(ck_out), .ck_oe(ck_oe), .dt_in(dt_line), .dt_out(dt_out), .dt_oe(dt_oe),
    .wake_request(wake_request), .int_request(int_request));
  usrx_sync_master m_u (.ck(m_ck), .dt(m_dt), .dt_en(m_en), .dt_line(dt_line));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // single ahb transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rdv);
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rdv);
    chk(what, e, rdv & m);
  endtask
  task automatic wait_bit(input string what, input logic [7:0] a, input logic [31:0] m);
    for (int i = 0; i < 300; i++) begin
      bus(1'b0, a, 32'h0, rdv);
      if ((rdv & m) === m) break;
    end
    chk(what, m, rdv & m);
  endtask
  // frame off the clock phase, then back onto an edge
  task automatic xfer(input logic [8:0] tx, input int n, input logic drv);
    #3;
    m_u.frame(tx, n, drv, rxw);
    @(posedge clk);
  endtask
  // async frame off the clock phase, then back onto an edge
  task automatic afr(input logic [7:0] d, input logic stop);
    #3;
    m_u.async_frame(d, stop);
    @(posedge clk);
  endtask
  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      end_sim();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    dt_last = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    core_sleep = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("rc reset", `USRX_A_RC, 32'hffffffff, 32'h0);
    rd("dir reset", `USRX_A_DIR, 32'hffffffff, 32'h3);
    wr(`USRX_A_RC, 32'hff);
    rd("rc read only", `USRX_A_RC, 32'hffffffff, 32'hf0);
    wr(`USRX_A_RC, 32'h0);
    wr(8'h1c, 32'hff);
    rd("unmapped", 8'h1c, 32'hffffffff, 32'h0);
    wr(`USRX_A_TXCTL, 32'h10);
    wr(`USRX_A_INT, 32'h04);
    wr(`USRX_A_RC, 32'ha0);
    xfer(9'h05a, 8, 1'b1);
    repeat (8) @(posedge clk);
    rd("single ignored", `USRX_A_INT, 32'h1, 32'h0);
    wr(`USRX_A_RC, 32'h90);
    xfer(9'h0a5, 8, 1'b1);
    wait_bit("rx done", `USRX_A_INT, 32'h1);
    chk("rx wake", 32'h1, {31'h0, wake_request});
    rd("rx 8 bit", `USRX_A_RBUF, 32'hffffffff, 32'ha5);
    core_sleep <= 1'b1;
    wr(`USRX_A_RC, 32'hd0);
    for (int i = 0; i < 2; i++) begin
      xfer(words[i], 9, 1'b1);
      wait_bit("rx asleep", `USRX_A_INT, 32'h1);
      chk("sleep wake", 32'h1, {31'h0, wake_request});
      rd("ninth bit", `USRX_A_RC, 32'hffffffff, {31'h68, words[i][8]});
      rd("rx 9 bit", `USRX_A_RBUF, 32'hffffffff, {24'h0, words[i][7:0]});
    end
    xfer(9'h011, 9, 1'b1);
    xfer(9'h022, 9, 1'b1);
    repeat (8) @(posedge clk);
    rd("overrun", `USRX_A_RC, 32'hffffffff, 32'hd2);
    rd("kept word", `USRX_A_RBUF, 32'hffffffff, 32'h11);
    rd("overrun held", `USRX_A_RC, 32'h2, 32'h2);
    wr(`USRX_A_RC, 32'hc0);
    rd("overrun clear", `USRX_A_RC, 32'hffffffff, 32'hc0);
    core_sleep <= 1'b0;
    wr(`USRX_A_RC, 32'h80);
    wr(`USRX_A_INT, 32'h18);
    wr(`USRX_A_TXCTL, 32'h30);
    wr(`USRX_A_TBUF, 32'h96);
    wr(`USRX_A_TBUF, 32'h69);
    core_sleep <= 1'b1;
    rd("tx flag held", `USRX_A_INT, 32'h2, 32'h0);
    chk("no tx wake", 32'h0, {31'h0, wake_request});
    xfer(9'h0, 8, 1'b0);
    chk("first word", 32'h96, {23'h0, rxw});
    wait_bit("tx flag", `USRX_A_INT, 32'h2);
    chk("tx wake", 32'h3, {30'h0, int_request, wake_request});
    xfer(9'h0, 8, 1'b0);
    chk("second word", 32'h69, {23'h0, rxw});
    core_sleep <= 1'b0;
    // master single receive at the top rate; the clock must park afterwards
    wr(`USRX_A_BAUD, 32'h0);
    wr(`USRX_A_TXCTL, 32'h90);
    wr(`USRX_A_RC, 32'ha0);
    chk("master drives clock", 32'h1, {31'h0, ck_oe});
    repeat (2) @(posedge ck_line);
    t0 = $time;
    @(posedge ck_line);
    chk("master clock period", 32'h28, 32'($time - t0));
    @(posedge clk);
    wait_bit("master rx", `USRX_A_INT, 32'h1);
    rd("single cleared", `USRX_A_RC, 32'h20, 32'h0);
    chk("clock parked", 32'h0, {31'h0, ck_out});
    bus(1'b0, `USRX_A_RBUF, 32'h0, rdv);
    // async reception: a bad stop bit, then a good one refreshes the flag
    wr(`USRX_A_TXCTL, 32'h0);
    wr(`USRX_A_RC, 32'h90);
    afr(8'h3c, 1'b0);
    wait_bit("async rx", `USRX_A_INT, 32'h1);
    rd("framing error", `USRX_A_RC, 32'h4, 32'h4);
    rd("async data", `USRX_A_RBUF, 32'hff, 32'h3c);
    afr(8'hc3, 1'b1);
    wait_bit("async rx again", `USRX_A_INT, 32'h1);
    rd("framing cleared", `USRX_A_RC, 32'h4, 32'h0);
    rd("async data again", `USRX_A_RBUF, 32'hff, 32'hc3);
    end_sim();
  end
endmodule
bind usrx_top usrx_chk chk_u (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .core_sleep(core_sleep), .ck_in(ck_in), .ck_oe(ck_oe), .dt_out(dt_out),
  .dt_oe(dt_oe), .wake_request(wake_request), .int_request(int_request));
`default_nettype wire
